// *** tll_top.sv ***
// Serial latch loader with power control and monitor multiplexer
`default_nettype none
`include "tll_cfg.svh"

module tll_top (
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic              clk_en,
   input  wire logic              serial_clk,
   input  wire logic              serial_data,
   input  wire logic              load_strobe,
   input  wire logic              power_enable,
   input  wire tll_pkg::tll_mon_src_s monitor_src,
   input  wire logic              pump_up_req,
   input  wire logic              pump_dn_req,
   output var  tll_pkg::tll_bank_t latch_bank_ff,
   output var  logic [3:0]        latch_wr_ff,
   output var  logic              powered_up_ff,
   output var  tll_pkg::tll_pump_s pump_output_ff,
   output var  logic              monitor_output_ff
);
   import tll_pkg::*;

   // ==========================================================
   // Functions
   function automatic tll_latch_e sel_of(input tll_word_t w);
      sel_of = tll_latch_e'(w[`TLL_SEL_LSB+1:`TLL_SEL_LSB]);
   endfunction : sel_of

   function automatic logic mon_pick(input tll_mon_e s, input tll_mon_src_s src);
      case (s)
         TLL_MON_LOCK: mon_pick = src.lock_detect;
         TLL_MON_RF:   mon_pick = src.rf_scaled;
         TLL_MON_REF:  mon_pick = src.ref_scaled;
         default:      mon_pick = 1'b0;
      endcase
   endfunction : mon_pick

   // ==========================================================
   // Serial clock domain shift register
   tll_word_t shift_ff;
   tll_word_t nxt_shift_ff;

   always_comb begin
      nxt_shift_ff = {shift_ff[`TLL_WORD_W-2:0], serial_data};
   end

   always_ff @(posedge serial_clk or negedge reset_n) begin
      if (!reset_n) begin
         shift_ff <= `TLL_SHIFT_RST;
      end else begin
         shift_ff <= nxt_shift_ff;
      end
   end

   chk_shift_in: assert property (@(posedge serial_clk) disable iff (!reset_n)
      1'b1 |=> shift_ff == {$past(shift_ff[`TLL_WORD_W-2:0]), $past(serial_data)})
      else $error("shift register did not take the data bit");

   // ==========================================================
   // Pin synchronisers
   logic [2:0] ld_sync_ff;
   logic [2:0] nxt_ld_sync_ff;
   logic [1:0] pe_sync_ff;
   logic [1:0] nxt_pe_sync_ff;
   logic       load_rise;

   always_comb begin
      nxt_ld_sync_ff = {ld_sync_ff[1:0], load_strobe};
      nxt_pe_sync_ff = {pe_sync_ff[0], power_enable};
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ld_sync_ff <= 3'h0;
         pe_sync_ff <= 2'h0;
      end else if (clk_en) begin
         ld_sync_ff <= nxt_ld_sync_ff;
         pe_sync_ff <= nxt_pe_sync_ff;
      end
   end

   assign load_rise = ld_sync_ff[1] & ~ld_sync_ff[2];

   // ==========================================================
   // Latch bank
   // The shift word is read only on a strobe rise, when the
   // serial clock stands still, so it is stable when sampled.
   tll_bank_t  nxt_latch_bank_ff;
   logic [3:0] nxt_latch_wr_ff;

   always_comb begin
      nxt_latch_bank_ff = latch_bank_ff;
      nxt_latch_wr_ff   = 4'h0;
      if (load_rise) begin
         nxt_latch_bank_ff[sel_of(shift_ff)] = shift_ff;
         nxt_latch_wr_ff[sel_of(shift_ff)]   = 1'h1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         latch_bank_ff <= {4{`TLL_LATCH_RST}};
         latch_wr_ff   <= 4'h0;
      end else if (clk_en) begin
         latch_bank_ff <= nxt_latch_bank_ff;
         latch_wr_ff   <= nxt_latch_wr_ff;
      end
   end

   // ==========================================================
   // Power and pump
   // A power-down bit in the control latch overrides the pin.
   logic       nxt_powered_up_ff;
   tll_pump_s  nxt_pump_output_ff;
   logic       pd_req;

   always_comb begin
      pd_req = latch_bank_ff[TLL_CONTROL][`TLL_PD1_BIT] |
               latch_bank_ff[TLL_CONTROL][`TLL_PD2_BIT];
      nxt_powered_up_ff     = pe_sync_ff[1] & ~pd_req;
      nxt_pump_output_ff.oe = nxt_powered_up_ff;
      nxt_pump_output_ff.up = nxt_powered_up_ff & pump_up_req;
      nxt_pump_output_ff.dn = nxt_powered_up_ff & pump_dn_req;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         powered_up_ff  <= 1'h0;
         pump_output_ff <= 3'h0;
      end else if (clk_en) begin
         powered_up_ff  <= nxt_powered_up_ff;
         pump_output_ff <= nxt_pump_output_ff;
      end
   end

   // ==========================================================
   // Monitor multiplexer
   // Follows the select field whatever the power state.
   logic       nxt_monitor_output_ff;
   tll_mon_e   mon_sel;

   always_comb begin
      mon_sel = tll_mon_e'(latch_bank_ff[TLL_CONTROL][`TLL_MUX_LSB+2:`TLL_MUX_LSB]);
      nxt_monitor_output_ff = mon_pick(mon_sel, monitor_src);
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         monitor_output_ff <= 1'h0;
      end else if (clk_en) begin
         monitor_output_ff <= nxt_monitor_output_ff;
      end
   end

   // ==========================================================
   // Checks
   chk_load_copy: assert property (@(posedge clk) disable iff (!reset_n)
      clk_en && load_rise |=> latch_bank_ff[$past(shift_ff[1:0])] == $past(shift_ff))
      else $error("loaded latch does not hold the shifted word");

   chk_no_strobe: assert property (@(posedge clk) disable iff (!reset_n)
      clk_en && !load_rise |=> latch_wr_ff == 4'h0)
      else $error("latch written without a strobe rise");

   chk_sel_control: assert property (@(posedge clk) disable iff (!reset_n)
      clk_en && load_rise && shift_ff[1:0] == 2'b00 |=> latch_wr_ff == 4'h1)
      else $error("select 00 did not reach the control latch");

   chk_sel_onehot: assert property (@(posedge clk) disable iff (!reset_n)
      clk_en && load_rise |=> latch_wr_ff == (4'h1 << $past(shift_ff[1:0])))
      else $error("latch select decode is wrong");

   chk_sel_test: assert property (@(posedge clk) disable iff (!reset_n)
      clk_en && load_rise && shift_ff[1:0] == 2'b11 |=> latch_wr_ff[3])
      else $error("select 11 did not reach the test latch");

   chk_pump_off: assert property (@(posedge clk) disable iff (!reset_n)
      clk_en && !pe_sync_ff[1] |=> !pump_output_ff.oe && !powered_up_ff)
      else $error("pump driven while power enable is low");

   chk_pd_bits: assert property (@(posedge clk) disable iff (!reset_n)
      clk_en && pd_req |=> !powered_up_ff && !pump_output_ff.oe)
      else $error("powered up against the power-down bits");

   chk_power_up: assert property (@(posedge clk) disable iff (!reset_n)
      clk_en && pe_sync_ff[1] && !pd_req |=> powered_up_ff && pump_output_ff.oe)
      else $error("did not power up when allowed");

   chk_mon_lock: assert property (@(posedge clk) disable iff (!reset_n)
      clk_en && mon_sel == TLL_MON_LOCK |=> monitor_output_ff == $past(monitor_src.lock_detect))
      else $error("monitor does not show lock detect");

   chk_mon_ref: assert property (@(posedge clk) disable iff (!reset_n)
      clk_en && mon_sel == TLL_MON_REF |=> monitor_output_ff == $past(monitor_src.ref_scaled))
      else $error("monitor does not show scaled reference");

   chk_sel_ref: assert property (@(posedge clk) disable iff (!reset_n)
      clk_en && load_rise && shift_ff[1:0] == 2'h1 |=> latch_wr_ff == 4'h2)
      else $error("select 01 did not reach the reference latch");

   chk_sel_fb: assert property (@(posedge clk) disable iff (!reset_n)
      clk_en && load_rise && shift_ff[1:0] == 2'h2 |=> latch_wr_ff == 4'h4)
      else $error("select 10 did not reach the feedback latch");

   chk_bank_hold: assert property (@(posedge clk) disable iff (!reset_n)
      clk_en && !load_rise |=> latch_bank_ff == $past(latch_bank_ff))
      else $error("latch bank changed without a strobe rise");

   chk_wr_pulse: assert property (@(posedge clk) disable iff (!reset_n)
      clk_en && latch_wr_ff != 4'h0 |=> latch_wr_ff == 4'h0)
      else $error("latch write mark lasted more than one cycle");

   chk_freeze_bank: assert property (@(posedge clk) disable iff (!reset_n)
      !clk_en |=> $stable(latch_bank_ff) && $stable(latch_wr_ff) && $stable(powered_up_ff))
      else $error("state changed while the clock enable was low");

   chk_pump_gate: assert property (@(posedge clk) disable iff (!reset_n)
      clk_en |=> (pump_output_ff.up == (powered_up_ff && $past(pump_up_req))) &&
                 (pump_output_ff.dn == (powered_up_ff && $past(pump_dn_req))))
      else $error("pump request passed while powered down");

   chk_mon_rf: assert property (@(posedge clk) disable iff (!reset_n)
      clk_en && mon_sel == TLL_MON_RF |=> monitor_output_ff == $past(monitor_src.rf_scaled))
      else $error("monitor does not show scaled feedback");

   chk_mon_idle: assert property (@(posedge clk) disable iff (!reset_n)
      clk_en && mon_sel > TLL_MON_REF |=> !monitor_output_ff)
      else $error("monitor not low for an unused select code");

endmodule : tll_top

`default_nettype wire

// *** tll_cfg.svh ***
// Constants of the three-wire latch loader
`ifndef TLL_CFG_SVH
`define TLL_CFG_SVH

`define TLL_WORD_W     24
`define TLL_SEL_LSB    0
`define TLL_PD1_BIT    20
`define TLL_PD2_BIT    21
`define TLL_MUX_LSB    5
`define TLL_SHIFT_RST  24'h000000
`define TLL_LATCH_RST  24'h000000

`endif

// *** tll_pkg.sv ***
// Types of the three-wire latch loader
`default_nettype none
`include "tll_cfg.svh"

package tll_pkg;
   typedef logic [`TLL_WORD_W-1:0] tll_word_t;

   typedef enum logic [1:0] {
      TLL_CONTROL,
      TLL_REF_COUNT,
      TLL_FB_COUNT,
      TLL_TEST
   } tll_latch_e;

   typedef enum logic [2:0] {
      TLL_MON_LOCK,
      TLL_MON_RF,
      TLL_MON_REF,
      TLL_MON_LOW0,
      TLL_MON_LOW1,
      TLL_MON_LOW2,
      TLL_MON_LOW3,
      TLL_MON_LOW4
   } tll_mon_e;

   typedef struct packed {
      logic lock_detect;
      logic rf_scaled;
      logic ref_scaled;
   } tll_mon_src_s;

   typedef struct packed {
      logic up;
      logic dn;
      logic oe;
   } tll_pump_s;

   typedef tll_word_t [3:0] tll_bank_t;
endpackage : tll_pkg

`default_nettype wire

// *** tll_host_model.sv ***
// Host controller model that clocks words into the latch loader
`default_nettype none
module tll_host_model (
   output var logic serial_clk,
   output var logic serial_data,
   output var logic load_strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   import tll_pkg::*;
   initial begin
      serial_clk  = 1'b0;
      serial_data = 1'b0;
      load_strobe = 1'b0;
   end
   // Serial clock runs only inside a frame
   task automatic send_word(input tll_word_t w);
      for (int i = 23; i >= 0; i--) begin
         serial_data = w[i];
         #15 serial_clk = 1'b1;
         #15 serial_clk = 1'b0;
      end
      // Released data line shows the inverse of the last bit
      serial_data = ~w[0];
      #10 load_strobe = 1'b1;
      #30 load_strobe = 1'b0;
      #30;
   endtask : send_word
endmodule : tll_host_model
`default_nettype wire

// *** tll_top_tb_top.sv ***
// Self-checking testbench of the three-wire latch loader
`default_nettype none
module tll_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import tll_pkg::*;
   logic         clk = 0, reset_n = 0, clk_en = 1, power_enable = 0;
   logic         pump_up_req = 0, pump_dn_req = 0, powered, mon;
   tll_mon_src_s monitor_src = '0;
   wire          serial_clk, serial_data, load_strobe;
   tll_bank_t    bank;
   logic [3:0]   wr, last_wr;
   tll_pump_s    pump;
   int           bad_count = 0, n_checks = 0;
   always #2.5 clk = ~clk;
   always @(posedge clk) if (wr !== 4'h0) last_wr <= wr;
   tll_host_model tll_host_model_inst (.serial_clk(serial_clk), .serial_data(serial_data),
      .load_strobe(load_strobe));
   tll_top tll_top_inst (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
      .serial_clk(serial_clk), .serial_data(serial_data), .load_strobe(load_strobe),
      .power_enable(power_enable), .monitor_src(monitor_src), .pump_up_req(pump_up_req),
      .pump_dn_req(pump_dn_req), .latch_bank_ff(bank), .latch_wr_ff(wr),
      .powered_up_ff(powered), .pump_output_ff(pump), .monitor_output_ff(mon));
   task automatic check(input string name, input logic [23:0] seen, exp);
      if (seen !== exp) begin
         $display("CHECK FAILED %s exp %h seen %h", name, exp, seen);
         bad_count++;
      end
      n_checks++;
   endtask : check
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   task automatic put(input tll_word_t w);
      last_wr = 4'h0;
      tll_host_model_inst.send_word(w);
      cyc(2);
      check("wr", last_wr, 4'h1 << w[1:0]);
      check("bank", bank[w[1:0]], w);
   endtask : put
   task automatic t_load();
      put(24'h123459);
      put(24'h000040);
      put(24'hABCDE6);
      put(24'h5A5A5A);
      check("hold", bank[1], 24'h123459);
      check("test", bank[3], 24'h0);
   endtask : t_load
   task automatic t_power();
      pump_up_req = 1;
      cyc(4);
      check("off", {powered, pump}, 4'h0);
      power_enable = 1;
      cyc(5);
      check("on", {powered, pump}, 4'hD);
      pump_up_req = 0;
      pump_dn_req = 1;
      cyc(2);
      check("dn", {powered, pump}, 4'hB);
      put(24'h100040);
      cyc(3);
      check("pd", {powered, pump.oe}, 2'h0);
      put(24'h200040);
      cyc(3);
      check("pd2", {powered, pump.oe}, 2'h0);
      put(24'h000040);
      cyc(3);
      check("up", {powered, pump.oe}, 2'h3);
   endtask : t_power
   task automatic t_freeze();
      clk_en = 0;
      power_enable = 0;
      cyc(6);
      check("frz", {powered, pump.oe}, 2'h3);
      clk_en = 1;
      cyc(5);
      check("down", {powered, pump.oe}, 2'h0);
   endtask : t_freeze
   task automatic t_mon();
      logic [2:0] s;
      for (int c = 0; c < 4; c++) begin
         put(24'(c) << 5);
         for (int k = 0; k < 2; k++) begin
            s = k ? 3'h5 : 3'h2;
            monitor_src = s;
            cyc(3);
            check("mon", mon, c < 3 ? s[2 - c] : 1'b0);
         end
      end
   endtask : t_mon
   task automatic test_done();
      if (bad_count == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done
   initial begin
      repeat (8) @(posedge clk);
      @(negedge clk) reset_n = 1;
      cyc(2);
      check("rst", {wr, powered, pump, mon}, 24'h0);
      t_load();
      t_power();
      t_freeze();
      t_mon();
      test_done();
   end
   initial begin
      #100000;
      bad_count++;
      test_done();
   end
endmodule : tll_top_tb_top
`default_nettype wire
